/* core/bmd_diag_fault_regs.sv */
// Diagnostic, supply fault and debug link control register bank on APB
//
// Contract
// RULE1: Each of eight input channels gets a fail bit when main and auxiliary readings differ by more than the input threshold, cleared on a pass.
// RULE2: Each of sixteen cells gets a fail bit when main and auxiliary cell readings differ by more than the cell threshold, split over two registers.
// RULE3: Each cell gets an open-wire fail bit when its reading is below the open-wire threshold, split over two registers.
// RULE4: Each balancing switch reports its open-wire check pass or fail, switches nine to sixteen in one register and one to eight in the next.
// RULE5: Each balancing switch reports its transistor check, one meaning fail, split the same way.
// RULE6: Open analog ground, digital ground and reference-low pins each set their own bit in the first supply register.
// RULE7: Communication supply under and over voltage, digital and analog over voltage and analog oscillation each have their own bit.
// RULE8: Software should ignore and clear an analog oscillation flag seen on the wake from sleep to active.
// RULE9: A digital reset from analog undervoltage, and a wake from shutdown, set the undervoltage reset flag.
// RULE10: Writing the unlock value to the unlock register activates the debug link control settings.
// RULE11: Writing any other value cancels all debug link control effects and restores normal behaviour.
// RULE12: The host transmit enable bit turns on the host transmitter, which a stack device otherwise keeps off.
// RULE13: Host transmit and mirror enables act only while the debug UART override bit is one.
// RULE14: The daisy link enables act only while the daisy override bit is one.
// RULE15: Four bits enable lower transmit, lower receive, upper transmit and upper receive, all enabled after reset.
// RULE16: All status registers are read-only and reset to zero.
// RULE17: Override bits and link enables act only while the unlock register holds the unlock value.
`timescale 1ns/10ps
`default_nettype none
module bmd_diag_fault_regs (
	input  wire logic        SYS_CLK,
	input  wire logic        NRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [12:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        DIAG_VALID,
	input  wire logic [1:0]  DIAG_KIND,
	input  wire logic [3:0]  DIAG_CHAN,
	input  wire logic [15:0] DIAG_MAIN,
	input  wire logic [15:0] DIAG_AUX,
	input  wire logic        BAL_VALID,
	input  wire logic [15:0] BAL_OPEN_FAIL,
	input  wire logic [15:0] BAL_SWITCH_FAIL,
	input  wire logic        MISC_VALID,
	input  wire logic [1:0]  MISC_RESULT,
	input  wire logic [7:0]  SUPPLY_FLAGS,
	input  wire logic        UV_RESET_EVENT,
	input  wire logic        SHUTDOWN_WAKE,
	input  wire logic        NORM_HOST_TX_EN,
	input  wire logic        NORM_HOST_MIRROR_EN,
	input  wire logic [3:0]  NORM_LINK_EN,
	output logic             HOST_TX_EN,
	output logic             HOST_MIRROR_ENABLE,
	output logic             HOST_SLOW_BAUD,
	output logic             LOWER_TRANSMIT_ENABLE,
	output logic             LOWER_RECEIVE_ENABLE,
	output logic             UPPER_TRANSMIT_ENABLE,
	output logic             UPPER_RECEIVE_ENABLE,
	output logic             IRQ
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0]                gpio_fail;
		logic [15:0]               cell_fail;
		logic [15:0]               ow_fail;
		logic [15:0]               bal_ow;
		logic [15:0]               bal_fet;
		logic [1:0]                misc;
		logic [7:0]                supply;
		logic                      uv_rst;
		logic [7:0]                unlock;
		logic [7:0]                ctrl1;
		logic [7:0]                ctrl2;
		logic [15:0]               thr_in;
		logic [15:0]               thr_cell;
		logic [15:0]               thr_ow;
		logic [bmd_pkg::IRQ_W-1:0] irq_stat;
		logic [bmd_pkg::IRQ_W-1:0] irq_mask;
		logic [7:0]                supply_prev;
		logic [1:0]                uvev_prev;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
		logic                      irq;
		logic                      host_tx;
		logic                      mirror;
		logic                      baud;
		logic [3:0]                link;
	} bmd_state_s;

	bmd_state_s                 s_q;
	bmd_state_s                 s_d;
	bmd_cmp_if                  cif ();
	logic [7:0]                 sup_sync;
	logic [1:0]                 ev_sync;
	logic                       uv_ev;
	logic [bmd_pkg::IDX_W-1:0]  idx;
	logic                       setup;
	logic                       wr_go;
	logic                       rd_go;
	logic                       unlocked;
	logic [bmd_pkg::IRQ_W-1:0]  ev;
	logic [7:0]                 sup_rise;

	// ****************************************************************
	// Submodules
	// ****************************************************************
	// Analog supply flags and reset causes cross in from the analog side
	bmd_sync3 #(.W(8)) u_sup_sync (
		.clk      (SYS_CLK),
		.rst_n    (NRST),
		.async_in (SUPPLY_FLAGS),
		.sync_out (sup_sync)
	);

	bmd_sync3 #(.W(2)) u_ev_sync (
		.clk      (SYS_CLK),
		.rst_n    (NRST),
		.async_in ({SHUTDOWN_WAKE, UV_RESET_EVENT}),
		.sync_out (ev_sync)
	);

	bmd_compare u_cmp (
		.cif (cif)
	);

	// Threshold chosen by comparison kind
	always_comb begin
		cif.kind    = bmd_pkg::bmd_kind_e'(DIAG_KIND);
		cif.main_rd = DIAG_MAIN;
		cif.aux_rd  = DIAG_AUX;
		case (bmd_pkg::bmd_kind_e'(DIAG_KIND))
			bmd_pkg::KIND_GPIO: begin
				cif.thr = s_q.thr_in;
			end
			bmd_pkg::KIND_CELL: begin
				cif.thr = s_q.thr_cell;
			end
			default: begin
				cif.thr = s_q.thr_ow;
			end
		endcase
	end

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	// Zero wait states: answer is set up during the setup cycle
	assign idx      = PADDR[12:2];
	assign setup    = PSEL && !PENABLE;
	assign wr_go    = PSEL && PENABLE && PWRITE && s_q.pready;
	assign rd_go    = PSEL && PENABLE && !PWRITE && s_q.pready;
	assign unlocked = (s_q.unlock == bmd_pkg::UNLOCK_CODE);  // [RULE17]
	assign uv_ev    = |(ev_sync & ~s_q.uvev_prev);  // Own edge per cause
	assign sup_rise = sup_sync & ~s_q.supply_prev;

	// Byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [31:0] wd, input logic [3:0] strb);
		merge16 = {strb[1] ? wd[15:8] : old_v[15:8],
			strb[0] ? wd[7:0] : old_v[7:0]};
	endfunction

	// Read mux; unknown index answers zero with an error
	function automatic logic [32:0] rd_mux(input logic [10:0] i,
		input bmd_state_s s, input logic unl);
		rd_mux = {1'b0, 32'h0000_0000};
		case (i)
			bmd_pkg::IDX_GPIO_CMP:   rd_mux[7:0]  = s.gpio_fail;
			bmd_pkg::IDX_CELL_HI:    rd_mux[7:0]  = s.cell_fail[15:8];
			bmd_pkg::IDX_CELL_LO:    rd_mux[7:0]  = s.cell_fail[7:0];
			bmd_pkg::IDX_OW_HI:      rd_mux[7:0]  = s.ow_fail[15:8];
			bmd_pkg::IDX_OW_LO:      rd_mux[7:0]  = s.ow_fail[7:0];
			bmd_pkg::IDX_BOW_HI:     rd_mux[7:0]  = s.bal_ow[15:8];
			bmd_pkg::IDX_BOW_LO:     rd_mux[7:0]  = s.bal_ow[7:0];
			bmd_pkg::IDX_BFET_HI:    rd_mux[7:0]  = s.bal_fet[15:8];
			bmd_pkg::IDX_BFET_LO:    rd_mux[7:0]  = s.bal_fet[7:0];
			bmd_pkg::IDX_MISC:       rd_mux[1:0]  = s.misc;
			bmd_pkg::IDX_PWR1:       rd_mux[7:0]  = s.supply;
			bmd_pkg::IDX_PWR2:       rd_mux[7:0]  = 8'h00;
			bmd_pkg::IDX_PWR3:       rd_mux[0]    = s.uv_rst;
			bmd_pkg::IDX_UNLOCK:     rd_mux[7:0]  = s.unlock;
			bmd_pkg::IDX_CTRL1:      rd_mux[7:0]  = s.ctrl1;
			bmd_pkg::IDX_CTRL2:      rd_mux[7:0]  = s.ctrl2;
			bmd_pkg::IDX_THR_INPUT:  rd_mux[15:0] = s.thr_in;
			bmd_pkg::IDX_THR_CELL:   rd_mux[15:0] = s.thr_cell;
			bmd_pkg::IDX_THR_OW:     rd_mux[15:0] = s.thr_ow;
			bmd_pkg::IDX_FAULT_CLR:  rd_mux[7:0]  = 8'h00;
			bmd_pkg::IDX_IRQ_STAT:   rd_mux[5:0]  = s.irq_stat;
			bmd_pkg::IDX_IRQ_MASK:   rd_mux[5:0]  = s.irq_mask;
			bmd_pkg::IDX_LINK_STATE: rd_mux[7:0]  = {unl, s.host_tx,
				s.mirror, s.baud, s.link};
			default:                 rd_mux[32]   = 1'b1;
		endcase
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		ev  = '0;

		// Bus answer: ready and data stand for the access cycle only
		s_d.pready  = setup;
		s_d.pslverr = 1'b0;
		s_d.prdata  = '0;
		if (setup) begin
			{s_d.pslverr, s_d.prdata} = rd_mux(idx, s_q, unlocked);
			if (PADDR[1:0] != 2'b00) begin
				s_d.pslverr = 1'b1;
				s_d.prdata  = '0;
			end
		end

		// Comparison results overwrite the channel bit: fail sets, pass clears
		if (DIAG_VALID) begin
			case (bmd_pkg::bmd_kind_e'(DIAG_KIND))
				bmd_pkg::KIND_GPIO: begin
					s_d.gpio_fail[DIAG_CHAN[2:0]] = cif.fail;  // [RULE1]
					ev[bmd_pkg::IRQ_GPIO] = cif.fail;
				end
				bmd_pkg::KIND_CELL: begin
					s_d.cell_fail[DIAG_CHAN] = cif.fail;       // [RULE2]
					ev[bmd_pkg::IRQ_CELL] = cif.fail;
				end
				bmd_pkg::KIND_OW: begin
					s_d.ow_fail[DIAG_CHAN] = cif.fail;         // [RULE3]
					ev[bmd_pkg::IRQ_OW] = cif.fail;
				end
				default: begin
					s_d.misc = s_q.misc;
				end
			endcase
		end

		// Balancing check results, high switches land in the high register
		if (BAL_VALID) begin
			s_d.bal_ow  = BAL_OPEN_FAIL;    // [RULE4]
			s_d.bal_fet = BAL_SWITCH_FAIL;  // [RULE5]
			ev[bmd_pkg::IRQ_BAL] = |{BAL_OPEN_FAIL, BAL_SWITCH_FAIL};
		end
		if (MISC_VALID) begin
			s_d.misc = MISC_RESULT;
		end

		// Supply faults latch on a rising flag; software clears them
		s_d.supply_prev = sup_sync;
		s_d.uvev_prev   = ev_sync;
		if (wr_go && idx == bmd_pkg::IDX_FAULT_CLR) begin
			if (PSTRB[0]) begin
				s_d.supply = s_q.supply & ~PWDATA[7:0];       // [RULE8]
			end
			if (PSTRB[1] && PWDATA[bmd_pkg::CLR_UVRST]) begin
				s_d.uv_rst = 1'b0;
			end
		end
		s_d.supply = s_d.supply | sup_rise;  // [RULE6] [RULE7]
		ev[bmd_pkg::IRQ_SUPPLY] = |sup_rise;
		// A wake behind a still-high undervoltage cause must count too
		if (uv_ev) begin
			s_d.uv_rst = 1'b1;               // [RULE9]
			ev[bmd_pkg::IRQ_UVRST] = 1'b1;
		end

		// Writable registers; status indices ignore writes
		if (wr_go && PSTRB[0]) begin
			case (idx)
				bmd_pkg::IDX_UNLOCK: begin
					s_d.unlock = PWDATA[7:0];  // [RULE10] [RULE11]
				end
				bmd_pkg::IDX_CTRL1: begin
					s_d.ctrl1 = {3'b000, PWDATA[4:0]};
				end
				bmd_pkg::IDX_CTRL2: begin
					s_d.ctrl2 = {4'h0, PWDATA[3:0]};  // [RULE15]
				end
				bmd_pkg::IDX_IRQ_MASK: begin
					s_d.irq_mask = PWDATA[bmd_pkg::IRQ_W-1:0];
				end
				default: begin
					s_d.ctrl2 = s_q.ctrl2;     // [RULE16]
				end
			endcase
		end
		if (wr_go) begin
			case (idx)
				bmd_pkg::IDX_THR_INPUT: begin
					s_d.thr_in = merge16(s_q.thr_in, PWDATA, PSTRB);
				end
				bmd_pkg::IDX_THR_CELL: begin
					s_d.thr_cell = merge16(s_q.thr_cell, PWDATA, PSTRB);
				end
				bmd_pkg::IDX_THR_OW: begin
					s_d.thr_ow = merge16(s_q.thr_ow, PWDATA, PSTRB);
				end
				default: begin
					s_d.thr_ow = s_d.thr_ow;
				end
			endcase
		end

		// Read clears only the bits returned, so a new event is never lost
		if (rd_go && idx == bmd_pkg::IDX_IRQ_STAT) begin
			s_d.irq_stat = s_q.irq_stat & ~s_q.prdata[bmd_pkg::IRQ_W-1:0];
		end
		s_d.irq_stat = s_d.irq_stat | ev;
		s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

		// Overrides apply only behind the key and their own enable bit
		if (unlocked && s_q.ctrl1[bmd_pkg::C1_UUART]) begin
			s_d.host_tx = s_q.ctrl1[bmd_pkg::C1_TX];         // [RULE12] [RULE13]
			s_d.mirror  = s_q.ctrl1[bmd_pkg::C1_MIRROR]
				& s_q.ctrl1[bmd_pkg::C1_TX];                  // [RULE13]
		end else begin
			s_d.host_tx = NORM_HOST_TX_EN;                   // [RULE17]
			s_d.mirror  = NORM_HOST_MIRROR_EN;
		end
		s_d.baud = unlocked & s_q.ctrl1[bmd_pkg::C1_BAUD];
		if (unlocked && s_q.ctrl1[bmd_pkg::C1_UDAISY]) begin
			s_d.link = s_q.ctrl2[3:0];                       // [RULE14]
		end else begin
			s_d.link = NORM_LINK_EN;                         // [RULE11]
		end
	end

	// Register the whole state; reset loads constants only
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			s_q       <= '0;                                 // [RULE16]
			s_q.ctrl1 <= bmd_pkg::CTRL1_RST;
			s_q.ctrl2 <= bmd_pkg::CTRL2_RST;                 // [RULE15]
			s_q.link  <= bmd_pkg::LINK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign PRDATA                = s_q.prdata;
	assign PREADY                = s_q.pready;
	assign PSLVERR               = s_q.pslverr;
	assign IRQ                   = s_q.irq;
	assign HOST_TX_EN            = s_q.host_tx;
	assign HOST_MIRROR_ENABLE    = s_q.mirror;
	assign HOST_SLOW_BAUD        = s_q.baud;
	assign LOWER_TRANSMIT_ENABLE = s_q.link[3];
	assign LOWER_RECEIVE_ENABLE  = s_q.link[2];
	assign UPPER_TRANSMIT_ENABLE = s_q.link[1];
	assign UPPER_RECEIVE_ENABLE  = s_q.link[0];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	a_gpio_fail_set: assert property (DIAG_VALID // [RULE1]
		&& DIAG_KIND == 2'h0 && ((DIAG_MAIN > DIAG_AUX)
		? DIAG_MAIN - DIAG_AUX : DIAG_AUX - DIAG_MAIN) > s_q.thr_in
		|=> s_q.gpio_fail[$past(DIAG_CHAN[2:0])])
		else $error("gpio compare fail bit not set");
	a_cell_pass_clear: assert property (DIAG_VALID // [RULE2]
		&& DIAG_KIND == 2'h1 && ((DIAG_MAIN > DIAG_AUX)
		? DIAG_MAIN - DIAG_AUX : DIAG_AUX - DIAG_MAIN) <= s_q.thr_cell
		|=> !s_q.cell_fail[$past(DIAG_CHAN)])
		else $error("cell compare pass did not clear bit");
	a_open_wire_set: assert property (DIAG_VALID // [RULE3]
		&& DIAG_KIND == 2'h2 && DIAG_MAIN < s_q.thr_ow
		|=> s_q.ow_fail[$past(DIAG_CHAN)])
		else $error("open wire fail bit not set");
	a_bal_open_load: assert property (BAL_VALID // [RULE4]
		|=> s_q.bal_ow == $past(BAL_OPEN_FAIL))
		else $error("balance open wire result not stored");
	a_bal_switch_load: assert property (BAL_VALID // [RULE5]
		|=> s_q.bal_fet == $past(BAL_SWITCH_FAIL))
		else $error("balance switch result not stored");
	a_supply_rise_flag: assert property (sup_rise != 8'h00 // [RULE6] [RULE7]
		|=> (s_q.supply & $past(sup_rise)) == $past(sup_rise))
		else $error("supply fault rise not latched");
	a_uv_reset_flag: assert property (uv_ev // [RULE9]
		|=> s_q.uv_rst ##1 (s_q.uv_rst || $past(wr_go)))
		else $error("undervoltage reset flag not set");
	a_daisy_override: assert property (unlocked // [RULE14] [RULE10]
		&& s_q.ctrl1[bmd_pkg::C1_UDAISY] |=> {LOWER_TRANSMIT_ENABLE,
		LOWER_RECEIVE_ENABLE, UPPER_TRANSMIT_ENABLE,
		UPPER_RECEIVE_ENABLE} == $past(s_q.ctrl2[3:0]))
		else $error("daisy override not applied");
	a_link_locked: assert property (!unlocked // [RULE11] [RULE17]
		|=> {LOWER_TRANSMIT_ENABLE,
		LOWER_RECEIVE_ENABLE, UPPER_TRANSMIT_ENABLE,
		UPPER_RECEIVE_ENABLE} == $past(NORM_LINK_EN)
		&& HOST_TX_EN == $past(NORM_HOST_TX_EN))
		else $error("locked device left normal link control");
	a_uart_override: assert property (unlocked // [RULE12] [RULE13]
		&& s_q.ctrl1[bmd_pkg::C1_UUART]
		|=> HOST_TX_EN == $past(s_q.ctrl1[bmd_pkg::C1_TX]))
		else $error("host transmit override not applied");
	a_status_ro: assert property (wr_go // [RULE16]
		&& idx == bmd_pkg::IDX_GPIO_CMP
		&& !DIAG_VALID |=> $stable(s_q.gpio_fail))
		else $error("status register changed by a write");
	a_apb_ready: assert property (setup |=> PREADY ##1 !PREADY)
		else $error("ready not a single access cycle");

	c_unlock_write: cover property (wr_go && idx == bmd_pkg::IDX_UNLOCK
		&& PWDATA[7:0] == bmd_pkg::UNLOCK_CODE);
	c_irq_rise: cover property ($rose(IRQ));
	c_bus_error: cover property (PREADY && PSLVERR);
endmodule
`default_nettype wire

/* core/bmd_pkg.sv */
// Package: register map, field layout and reset values of the diagnostic bank
package bmd_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam int unsigned IDX_W    = 11;
	localparam int unsigned ADDR_W   = 13;
	localparam logic [IDX_W-1:0] IDX_GPIO_CMP   = 11'h543;
	localparam logic [IDX_W-1:0] IDX_CELL_HI    = 11'h545;
	localparam logic [IDX_W-1:0] IDX_CELL_LO    = 11'h546;
	localparam logic [IDX_W-1:0] IDX_OW_HI      = 11'h548;
	localparam logic [IDX_W-1:0] IDX_OW_LO      = 11'h549;
	localparam logic [IDX_W-1:0] IDX_BOW_HI     = 11'h54b;
	localparam logic [IDX_W-1:0] IDX_BOW_LO     = 11'h54c;
	localparam logic [IDX_W-1:0] IDX_BFET_HI    = 11'h54e;
	localparam logic [IDX_W-1:0] IDX_BFET_LO    = 11'h54f;
	localparam logic [IDX_W-1:0] IDX_MISC       = 11'h550;
	localparam logic [IDX_W-1:0] IDX_PWR1       = 11'h552;
	localparam logic [IDX_W-1:0] IDX_PWR2       = 11'h553;
	localparam logic [IDX_W-1:0] IDX_PWR3       = 11'h554;
	localparam logic [IDX_W-1:0] IDX_UNLOCK     = 11'h700;
	localparam logic [IDX_W-1:0] IDX_CTRL1      = 11'h701;
	localparam logic [IDX_W-1:0] IDX_CTRL2      = 11'h702;
	localparam logic [IDX_W-1:0] IDX_THR_INPUT  = 11'h7f0;
	localparam logic [IDX_W-1:0] IDX_THR_CELL   = 11'h7f1;
	localparam logic [IDX_W-1:0] IDX_THR_OW     = 11'h7f2;
	localparam logic [IDX_W-1:0] IDX_FAULT_CLR  = 11'h7f3;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 11'h7f4;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 11'h7f5;
	localparam logic [IDX_W-1:0] IDX_LINK_STATE = 11'h7f6;

	// ****************************************************************
	// Widths, reset values and field positions
	// ****************************************************************
	localparam int unsigned RD_W   = 16;
	localparam int unsigned IRQ_W  = 6;
	localparam logic [7:0]  UNLOCK_CODE = 8'ha5;
	localparam logic [7:0]  CTRL1_RST   = 8'h04;
	localparam logic [7:0]  CTRL2_RST   = 8'h0f;
	localparam logic [3:0]  LINK_RST    = 4'hf;
	localparam int unsigned C1_BAUD     = 4;
	localparam int unsigned C1_MIRROR   = 3;
	localparam int unsigned C1_TX       = 2;
	localparam int unsigned C1_UUART    = 1;
	localparam int unsigned C1_UDAISY   = 0;
	localparam int unsigned CLR_UVRST   = 8;
	localparam int unsigned IRQ_GPIO    = 0;
	localparam int unsigned IRQ_CELL    = 1;
	localparam int unsigned IRQ_OW      = 2;
	localparam int unsigned IRQ_BAL     = 3;
	localparam int unsigned IRQ_SUPPLY  = 4;
	localparam int unsigned IRQ_UVRST   = 5;

	// Measurement comparison kinds
	typedef enum logic [1:0] {
		KIND_GPIO,
		KIND_CELL,
		KIND_OW
	} bmd_kind_e;

endpackage

/* core/bmd_cmp_if.sv */
// Interface: carries one comparison request and its verdict
`timescale 1ns/10ps
`default_nettype none
interface bmd_cmp_if;
	bmd_pkg::bmd_kind_e            kind;
	logic [bmd_pkg::RD_W-1:0]      main_rd;
	logic [bmd_pkg::RD_W-1:0]      aux_rd;
	logic [bmd_pkg::RD_W-1:0]      thr;
	logic                          fail;
	modport ctl (output kind, output main_rd, output aux_rd, output thr,
		input fail);
	modport cmp (input kind, input main_rd, input aux_rd, input thr,
		output fail);
endinterface
`default_nettype wire

/* core/bmd_compare.sv */
// Comparator: main versus auxiliary reading, or reading versus floor
`timescale 1ns/10ps
`default_nettype none
module bmd_compare (
	bmd_cmp_if.cmp cif
);
	logic [bmd_pkg::RD_W-1:0] diff;

	// Absolute difference for cross checks, plain floor for open wire
	always_comb begin
		diff = (cif.main_rd > cif.aux_rd) ? cif.main_rd - cif.aux_rd
			: cif.aux_rd - cif.main_rd;
		case (cif.kind)
			bmd_pkg::KIND_OW: begin
				cif.fail = cif.main_rd < cif.thr;  // [RULE3]
			end
			bmd_pkg::KIND_GPIO,
			bmd_pkg::KIND_CELL: begin
				cif.fail = diff > cif.thr;         // [RULE1] [RULE2]
			end
			default: begin
				cif.fail = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* core/bmd_sync3.sv */
// Three-stage synchroniser bank with agreement filter
`timescale 1ns/10ps
`default_nettype none
module bmd_sync3 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] held;
	} bmd_sync_s;

	bmd_sync_s s_q;
	bmd_sync_s s_d;

	// A change is accepted only once stages two and three agree
	always_comb begin
		s_d      = s_q;
		s_d.s1   = async_in;
		s_d.s2   = s_q.s1;
		s_d.s3   = s_q.s2;
		s_d.held = (s_q.s2 & s_q.s3) | (s_q.held & (s_q.s2 ^ s_q.s3));
	end

	// Synchronous reset, constant only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.held;
endmodule
`default_nettype wire

/* verification/bmd_far_side.sv */
// Far-side model: supply monitors and normal link controls
`timescale 1ns/10ps
`default_nettype none
module bmd_far_side (
	input  wire logic       clk,
	input  wire logic [7:0] sup_req,
	input  wire logic       uv_req,
	output var logic  [7:0] sup_flags = 8'h0,
	output var logic        uv_event = 1'b0,
	output logic            norm_tx,
	output logic      [3:0] norm_link
);
	// Stack default: host transmitter off, daisy ports on
	assign norm_tx = 1'b0;
	assign norm_link = 4'hf;
	// Monitors move just after an edge, never in step with the sampler
	always @(posedge clk) begin
		sup_flags <= sup_req;
		uv_event <= uv_req;
	end
endmodule
`default_nettype wire

/* verification/bmd_diag_fault_regs_test.sv */
// Testbench: registers, diagnostics, supply faults and link overrides
`timescale 1ns/10ps
`default_nettype none
module bmd_diag_fault_regs_test;
	logic        SYS_CLK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
	logic        PWRITE = 1'b0, DIAG_VALID = 1'b0, BAL_VALID = 1'b0;
	logic        MISC_VALID = 1'b0, SHUTDOWN_WAKE = 1'b0;
	logic        uv_req = 1'b0, er, PREADY, PSLVERR, IRQ, HOST_TX_EN;
	logic        HOST_MIRROR_ENABLE, HOST_SLOW_BAUD, UV_RESET_EVENT, NORM_TX;
	logic        LOWER_TRANSMIT_ENABLE, LOWER_RECEIVE_ENABLE;
	logic        UPPER_TRANSMIT_ENABLE, UPPER_RECEIVE_ENABLE;
	logic [12:0] PADDR = 13'h0;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic [1:0]  DIAG_KIND = 2'h0, MISC_RESULT = 2'h0;
	logic [3:0]  DIAG_CHAN = 4'h0, NORM_LINK_EN;
	logic [15:0] DIAG_MAIN = 16'h0, DIAG_AUX = 16'h0;
	logic [15:0] BAL_OPEN_FAIL = 16'h0, BAL_SWITCH_FAIL = 16'h0;
	logic [7:0]  sup_req = 8'h0, SUPPLY_FLAGS;
	int          failures = 0, checked = 0;

	always #2.5 SYS_CLK = ~SYS_CLK;

	bmd_diag_fault_regs i_dut (.SYS_CLK, .NRST, .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PSTRB(4'hf), .PRDATA, .PREADY, .PSLVERR,
		.DIAG_VALID, .DIAG_KIND, .DIAG_CHAN, .DIAG_MAIN, .DIAG_AUX,
		.BAL_VALID, .BAL_OPEN_FAIL, .BAL_SWITCH_FAIL, .MISC_VALID,
		.MISC_RESULT, .SUPPLY_FLAGS, .UV_RESET_EVENT,
		.SHUTDOWN_WAKE, .NORM_HOST_TX_EN(NORM_TX),
		.NORM_HOST_MIRROR_EN(NORM_TX), .NORM_LINK_EN, .HOST_TX_EN,
		.HOST_MIRROR_ENABLE, .HOST_SLOW_BAUD, .LOWER_TRANSMIT_ENABLE,
		.LOWER_RECEIVE_ENABLE, .UPPER_TRANSMIT_ENABLE,
		.UPPER_RECEIVE_ENABLE, .IRQ);
	bmd_far_side i_far (.clk(SYS_CLK), .sup_req, .uv_req,
		.sup_flags(SUPPLY_FLAGS), .uv_event(UV_RESET_EVENT),
		.norm_tx(NORM_TX), .norm_link(NORM_LINK_EN));

	task automatic chk(input string n, input logic [31:0] x, g);
		checked++;
		if (g !== x) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask

	// One APB transfer; a read is compared with d at once
	task automatic xf(input logic w, input logic [10:0] i,
		input logic [31:0] d, input string n);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= {i, 2'b00};
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		// Ready, data and error are taken at the rising edge that ends access
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (!w)
			chk(n, d, rd);
	endtask

	// Outputs settle one cycle after the control write edge
	task automatic lk(input logic [6:0] x);
		repeat (2) @(negedge SYS_CLK);
		chk("links", {25'h0, x}, {25'h0, HOST_SLOW_BAUD, HOST_TX_EN,
			HOST_MIRROR_ENABLE,
			LOWER_TRANSMIT_ENABLE, LOWER_RECEIVE_ENABLE,
			UPPER_TRANSMIT_ENABLE, UPPER_RECEIVE_ENABLE});
	endtask

	task automatic dg(input logic [1:0] k, input logic [3:0] c,
		input logic [15:0] m, a);
		@(posedge SYS_CLK);
		DIAG_VALID <= 1'b1;
		DIAG_KIND <= k;
		DIAG_CHAN <= c;
		DIAG_MAIN <= m;
		DIAG_AUX <= a;
		@(posedge SYS_CLK);
		DIAG_VALID <= 1'b0;
	endtask

	task automatic summarize;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge SYS_CLK);
		failures++;
		summarize;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (4) @(posedge SYS_CLK);
		NRST <= 1'b1;
		xf(1'b1, 11'h543, 32'hff, "");
		xf(1'b0, 11'h543, 32'h0, "gpio ro");
		xf(1'b0, 11'h701, 32'h04, "ctrl1");
		xf(1'b0, 11'h702, 32'h0f, "ctrl2");
		xf(1'b0, 11'h700, 32'h0, "unlock");
		xf(1'b0, 11'h544, 32'h0, "hole");
		chk("slverr", 32'h1, {31'h0, er});
		xf(1'b1, 11'h7f0, 32'd10, "");
		xf(1'b1, 11'h7f1, 32'd10, "");
		xf(1'b1, 11'h7f2, 32'd100, "");
		dg(2'h0, 4'h7, 16'd50, 16'd30);
		xf(1'b0, 11'h543, 32'h80, "gpio fail");
		chk("irq masked", 32'h0, {31'h0, IRQ});
		dg(2'h0, 4'h7, 16'd50, 16'd45);
		xf(1'b0, 11'h543, 32'h0, "gpio pass");
		dg(2'h1, 4'h2, 16'd100, 16'd80);
		dg(2'h1, 4'hf, 16'd0, 16'd11);
		dg(2'h1, 4'h0, 16'd10, 16'd0);
		xf(1'b0, 11'h546, 32'h04, "cell lo");
		xf(1'b0, 11'h545, 32'h80, "cell hi");
		dg(2'h2, 4'h9, 16'd99, 16'd0);
		dg(2'h2, 4'h8, 16'd100, 16'd0);
		xf(1'b0, 11'h548, 32'h02, "ow hi");
		BAL_OPEN_FAIL <= 16'h0102;
		BAL_SWITCH_FAIL <= 16'h8001;
		BAL_VALID <= 1'b1;
		MISC_RESULT <= 2'h1;
		MISC_VALID <= 1'b1;
		@(posedge SYS_CLK);
		BAL_VALID <= 1'b0;
		MISC_VALID <= 1'b0;
		xf(1'b0, 11'h550, 32'h01, "misc");
		xf(1'b0, 11'h54b, 32'h01, "bow hi");
		xf(1'b0, 11'h54c, 32'h02, "bow lo");
		xf(1'b0, 11'h54e, 32'h80, "fet hi");
		xf(1'b0, 11'h54f, 32'h01, "fet lo");
		xf(1'b0, 11'h7f4, 32'h0f, "irq stat");
		xf(1'b1, 11'h702, 32'h05, "");
		xf(1'b1, 11'h701, 32'h07, "");
		lk(7'h0f);
		xf(1'b1, 11'h700, 32'ha5, "");
		lk(7'h25);
		xf(1'b0, 11'h7f6, 32'hc5, "link state");
		xf(1'b1, 11'h701, 32'h0c, "");
		lk(7'h0f);
		xf(1'b1, 11'h701, 32'h1e, "");
		lk(7'h7f);
		xf(1'b1, 11'h700, 32'h5a, "");
		lk(7'h0f);
		xf(1'b1, 11'h7f5, 32'h10, "");
		sup_req <= 8'h83;
		repeat (8) @(negedge SYS_CLK);
		chk("irq", 32'h1, {31'h0, IRQ});
		xf(1'b0, 11'h552, 32'h83, "supply");
		xf(1'b0, 11'h7f4, 32'h10, "irq stat");
		@(negedge SYS_CLK);
		chk("irq off", 32'h0, {31'h0, IRQ});
		xf(1'b1, 11'h7f3, 32'h02, "");
		xf(1'b0, 11'h552, 32'h81, "osc clr");
		uv_req <= 1'b1;
		repeat (8) @(negedge SYS_CLK);
		xf(1'b0, 11'h554, 32'h01, "uv rst");
		xf(1'b1, 11'h7f3, 32'h100, "");
		xf(1'b0, 11'h554, 32'h0, "uv clr");
		SHUTDOWN_WAKE <= 1'b1;
		repeat (8) @(negedge SYS_CLK);
		xf(1'b0, 11'h554, 32'h01, "wake");
		summarize;
	end
endmodule
`default_nettype wire
